// file: logic/iep_pkg.sv
/*
 * Package for the interrupt enable and priority block: register offsets,
 * field positions, reset values, source order and carrier structs.
 * Assumes an 8-bit special-function register space.
 */
package iep_pkg;

    localparam int NUM_SRC = 6;

    // Register offsets
    localparam logic [7:0] IRQ_ENABLE_MASK_ADDR = 8'hA8;
    localparam logic [7:0] IRQ_PRIO_UPPER_ADDR = 8'hB7;
    localparam logic [7:0] IRQ_PRIO_LOWER_ADDR = 8'hB8;
    localparam logic [7:0] IRQ_STATUS_ADDR = 8'hB9;

    // Enable register fields
    localparam int GLOBAL_IRQ_GATE_BIT = 7;
    localparam int ENABLE_RSVD_BIT = 6;
    localparam int TMR2_OVF_EN_BIT = 5;
    localparam int SERIAL_IRQ_ON_BIT = 4;
    localparam int TMR1_OVF_EN_BIT = 3;
    localparam int EXT1_IRQ_EN_BIT = 2;
    localparam int TMR0_OVF_EN_BIT = 1;
    localparam int EXT0_IRQ_EN_BIT = 0;

    // Source indices, also the fixed polling order (lowest index first)
    localparam int SRC_EXT0 = 0;
    localparam int SRC_TMR0 = 1;
    localparam int SRC_EXT1 = 2;
    localparam int SRC_TMR1 = 3;
    localparam int SRC_SERIAL = 4;
    localparam int SRC_TMR2 = 5;

    // Reset values
    localparam logic [7:0] IRQ_ENABLE_MASK_RST = 8'h00;
    localparam logic [7:0] IRQ_PRIO_UPPER_RST = 8'h00;
    localparam logic [7:0] IRQ_PRIO_LOWER_RST = 8'h00;

    // Reserved bits read back as this value
    localparam logic RSVD_READ_VAL = 1'b0;

    localparam logic [2:0] NO_SRC = 3'h7;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
        logic bit_op;
        logic [2:0] bit_sel;
    } iep_bus_req_t;

    typedef struct packed {
        logic valid;
        logic [2:0] src;
        logic [1:0] level;
    } iep_grant_t;

endpackage : iep_pkg

// file: logic/iep_level_pick.sv
/*
 * Picks the first requesting source, in polling order, among those at one
 * priority level. Assumes one-hot-free request vector of NUM requesters.
 */
`timescale 1ns/100ps
module iep_level_pick #(
    parameter int NUM = 6
) (
    // Requests
    input wire logic [NUM-1:0] req_in,
    input wire logic [NUM*2-1:0] level_in,
    input wire logic [1:0] want_level_in,
    // Result
    output logic hit_out,
    output logic [2:0] src_out
);

    // Code 7 is the no-source answer, so at most seven requesters
    if (NUM < 1 || NUM > 7) begin : g_bad_num
        $error("iep_level_pick: NUM out of range");
    end

    always_comb begin
        hit_out = 1'b0;
        src_out = iep_pkg::NO_SRC;
        for (int i = NUM - 1; i >= 0; i--) begin
            if (req_in[i] && level_in[i*2 +: 2] == want_level_in) begin
                hit_out = 1'b1;
                src_out = 3'(i);
            end
        end
    end

endmodule : iep_level_pick

// file: logic/iep_irq_ctrl.sv
/*
 * Interrupt enable and priority configuration with request arbitration.
 * Assumes a core sequencer that acknowledges the granted source and tells
 * the block when a service routine returns; requests are level flags.
 */
// Added by the designer: the address-and-strobe port.
`timescale 1ns/100ps
module iep_irq_ctrl #(
    parameter int NUM_SRC = iep_pkg::NUM_SRC
) (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic reset_in,
    // Register port
    input wire iep_pkg::iep_bus_req_t bus_in,
    output logic [7:0] rdata_out,
    // Peripheral request flags
    input wire logic [NUM_SRC-1:0] src_req_in,
    // Core sequencer
    input wire logic grant_ack_in,
    input wire logic service_done_in,
    output iep_pkg::iep_grant_t grant_out,
    output logic [7:0] status_out
);

    ////////////////////////////////////////////////////////////////////////
    // Elaboration checks

    // Gating and level wiring are written for six sources
    if (NUM_SRC != 6) begin : g_bad_num_src
        $error("iep_irq_ctrl: exactly six sources are supported");
    end
    // Read mux places the gate and the spare bit by hand
    if (iep_pkg::GLOBAL_IRQ_GATE_BIT != 7 || iep_pkg::ENABLE_RSVD_BIT != 6) begin : g_bad_layout
        $error("iep_irq_ctrl: enable register layout not served");
    end
    // Shared offsets would let one write land in two registers
    if (iep_pkg::IRQ_ENABLE_MASK_ADDR == iep_pkg::IRQ_PRIO_UPPER_ADDR ||
        iep_pkg::IRQ_ENABLE_MASK_ADDR == iep_pkg::IRQ_PRIO_LOWER_ADDR ||
        iep_pkg::IRQ_PRIO_UPPER_ADDR == iep_pkg::IRQ_PRIO_LOWER_ADDR) begin : g_bad_map
        $error("iep_irq_ctrl: register offsets overlap");
    end
    // No-source code must never name a real source
    if (int'(iep_pkg::NO_SRC) < NUM_SRC) begin : g_bad_no_src
        $error("iep_irq_ctrl: no-source code collides with a source");
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers

    logic [7:0] enable_ff;
    logic [7:0] nxt_enable;
    logic [5:0] prio_upper_ff;
    logic [5:0] nxt_prio_upper;
    logic [5:0] prio_lower_ff;
    logic [5:0] nxt_prio_lower;
    logic [3:0] active_ff;
    logic [3:0] nxt_active;
    logic [1:0] cur_level;
    logic in_service;

    // Whole-byte write, or single-bit set/clear on bit_sel with wdata[0]
    function automatic logic [7:0] apply_write(input logic [7:0] old,
                                               input iep_pkg::iep_bus_req_t b);
        logic [7:0] r;
        r = old;
        if (b.bit_op) begin
            r[b.bit_sel] = b.wdata[0];
        end else begin
            r = b.wdata;
        end
        return r;
    endfunction : apply_write

    // Address decodes shared by the three write paths
    logic hit_enable;
    logic hit_upper;
    logic hit_lower;

    assign hit_enable = bus_in.addr == iep_pkg::IRQ_ENABLE_MASK_ADDR;
    assign hit_upper = bus_in.addr == iep_pkg::IRQ_PRIO_UPPER_ADDR;
    assign hit_lower = bus_in.addr == iep_pkg::IRQ_PRIO_LOWER_ADDR;

    always_comb begin
        nxt_enable = enable_ff;
        if (bus_in.wr && hit_enable) begin
            nxt_enable = apply_write(enable_ff, bus_in);
        end
        // Reserved bit never stored, so a stray one cannot matter
        nxt_enable[iep_pkg::ENABLE_RSVD_BIT] = 1'b0;
    end

    always_comb begin
        logic [7:0] tmp;
        tmp = {2'h0, prio_upper_ff};
        nxt_prio_upper = prio_upper_ff;
        // Upper priority register is byte-wide only
        if (bus_in.wr && !bus_in.bit_op && hit_upper) begin
            tmp = bus_in.wdata;
            nxt_prio_upper = tmp[5:0];
        end
    end

    always_comb begin
        logic [7:0] tmp;
        tmp = apply_write({2'h0, prio_lower_ff}, bus_in);
        nxt_prio_lower = prio_lower_ff;
        if (bus_in.wr && hit_lower) begin
            nxt_prio_lower = tmp[5:0];
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            enable_ff <= iep_pkg::IRQ_ENABLE_MASK_RST;
        end else begin
            enable_ff <= nxt_enable;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            prio_upper_ff <= iep_pkg::IRQ_PRIO_UPPER_RST[5:0];
            prio_lower_ff <= iep_pkg::IRQ_PRIO_LOWER_RST[5:0];
        end else begin
            prio_upper_ff <= nxt_prio_upper;
            prio_lower_ff <= nxt_prio_lower;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Gating and level formation

    logic [5:0] src_en;
    logic [5:0] gated_req;
    logic [11:0] levels;

    always_comb begin
        src_en = '0;
        src_en[iep_pkg::SRC_EXT0] = enable_ff[iep_pkg::EXT0_IRQ_EN_BIT];
        src_en[iep_pkg::SRC_TMR0] = enable_ff[iep_pkg::TMR0_OVF_EN_BIT];
        src_en[iep_pkg::SRC_EXT1] = enable_ff[iep_pkg::EXT1_IRQ_EN_BIT];
        src_en[iep_pkg::SRC_TMR1] = enable_ff[iep_pkg::TMR1_OVF_EN_BIT];
        src_en[iep_pkg::SRC_SERIAL] = enable_ff[iep_pkg::SERIAL_IRQ_ON_BIT];
        src_en[iep_pkg::SRC_TMR2] = enable_ff[iep_pkg::TMR2_OVF_EN_BIT];
        // Requests are level flags; a served source must drop its own
        // Gate first, then per-source enable
        if (enable_ff[iep_pkg::GLOBAL_IRQ_GATE_BIT]) begin
            gated_req = src_req_in & src_en;
        end else begin
            gated_req = '0;
        end
        for (int i = 0; i < 6; i++) begin
            levels[i*2 +: 2] = {prio_upper_ff[i], prio_lower_ff[i]};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Arbitration: one picker per level, highest level wins

    logic [3:0] lvl_hit;
    logic [2:0] lvl_src [4];

    for (genvar g = 0; g < 4; g++) begin : g_lvl
        iep_level_pick #(
            .NUM(6)
        ) u_pick (
            .req_in(gated_req),
            .level_in(levels),
            .want_level_in(2'(g)),
            .hit_out(lvl_hit[g]),
            .src_out(lvl_src[g])
        );
    end

    logic win_valid;
    logic [2:0] win_src;
    logic [1:0] win_level;

    always_comb begin
        win_valid = 1'b0;
        win_src = iep_pkg::NO_SRC;
        win_level = 2'h0;
        for (int l = 0; l < 4; l++) begin
            if (lvl_hit[l]) begin
                win_valid = 1'b1;
                win_src = lvl_src[l];
                win_level = 2'(l);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Service tracking: one active bit per level, nested routines

    always_comb begin
        in_service = |active_ff;
        cur_level = 2'h0;
        for (int l = 0; l < 4; l++) begin
            if (active_ff[l]) begin
                cur_level = 2'(l);
            end
        end
    end

    logic may_grant;
    // Equal level waits for the return; only a strictly higher level nests
    assign may_grant = win_valid && (!in_service || win_level > cur_level);

    always_comb begin
        nxt_active = active_ff;
        // Return clears the highest active level; a new grant can stack above it
        if (service_done_in && in_service) begin
            nxt_active[cur_level] = 1'b0;
        end
        if (grant_ack_in && grant_out.valid) begin
            nxt_active[grant_out.level] = 1'b1;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            active_ff <= 4'h0;
        end else begin
            active_ff <= nxt_active;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            grant_out <= '0;
        end else if (grant_ack_in && grant_out.valid) begin
            // One-cycle gap lets the active level settle before the next offer
            grant_out <= '0;
        end else begin
            // Offer tracks the winner, so a withdrawn request drops it
            grant_out.valid <= may_grant;
            grant_out.src <= win_src;
            grant_out.level <= win_level;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            status_out <= 8'h00;
        end else begin
            status_out <= {2'h0, gated_req};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Software status byte

    logic [7:0] status_rd;
    logic deep_level;

    always_comb begin
        // Coarse flag only: levels 2 and 3 share one code
        deep_level = active_ff[3] || active_ff[2];
        status_rd = 8'h00;
        status_rd[6] = in_service;
        status_rd[5:4] = deep_level ? 2'h3 : 2'h0;
        status_rd[2:0] = win_valid ? win_src : iep_pkg::NO_SRC;
    end

    ////////////////////////////////////////////////////////////////////////
    // Read port

    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            rdata_out <= 8'h00;
        end else if (bus_in.rd) begin
            case (bus_in.addr)
                iep_pkg::IRQ_ENABLE_MASK_ADDR: begin
                    rdata_out <= {enable_ff[7], iep_pkg::RSVD_READ_VAL,
                                  enable_ff[5:0]};
                end
                iep_pkg::IRQ_PRIO_UPPER_ADDR: begin
                    rdata_out <= {iep_pkg::RSVD_READ_VAL, iep_pkg::RSVD_READ_VAL,
                                  prio_upper_ff};
                end
                iep_pkg::IRQ_PRIO_LOWER_ADDR: begin
                    rdata_out <= {2'h0, prio_lower_ff};
                end
                iep_pkg::IRQ_STATUS_ADDR: begin
                    rdata_out <= status_rd;
                end
                default: begin
                    rdata_out <= 8'h00;
                end
            endcase
        end else begin
            rdata_out <= 8'h00;
        end
    end

endmodule : iep_irq_ctrl

// file: tb/iep_irq_asserts.sv
/* Port checker for the interrupt enable and priority block.
   Assumes binding onto every instance of iep_irq_ctrl. */
`timescale 1ns/100ps
module iep_irq_asserts #(
    parameter int NUM_SRC = 6
) (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic reset_in,
    // Register port
    input wire iep_pkg::iep_bus_req_t bus_in,
    input wire logic [7:0] rdata_out,
    // Requests and sequencer
    input wire logic [NUM_SRC-1:0] src_req_in,
    input wire logic grant_ack_in,
    input wire logic service_done_in,
    input wire iep_pkg::iep_grant_t grant_out,
    input wire logic [7:0] status_out
);
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (reset_in);
    ////////////////////////////////////////////////////////////////
    property p_rst_quiet;
        $past(reset_in) |-> rdata_out == 8'h00 && !grant_out.valid && status_out == 8'h00;
    endproperty
    a_rst_quiet: assert property (p_rst_quiet) else $error("outputs busy after reset");
    property p_rd_only;
        !$past(bus_in.rd) |-> rdata_out == 8'h00;
    endproperty
    a_rd_only: assert property (p_rd_only) else $error("read data without read");
    property p_ie_rsvd;
        bus_in.rd && bus_in.addr == iep_pkg::IRQ_ENABLE_MASK_ADDR |=> !rdata_out[6];
    endproperty
    a_ie_rsvd: assert property (p_ie_rsvd) else $error("enable spare bit read set");
    property p_iph_rsvd;
        bus_in.rd && bus_in.addr == iep_pkg::IRQ_PRIO_UPPER_ADDR |=> rdata_out[7:6] == 2'h0;
    endproperty
    a_iph_rsvd: assert property (p_iph_rsvd) else $error("upper spare bits read set");
    property p_unmapped;
        bus_in.rd && !(bus_in.addr inside {8'hA8, 8'hB7, 8'hB8, 8'hB9}) |=> rdata_out == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_grant_gated;
        grant_out.valid |-> status_out[grant_out.src] && grant_out.src < 3'h6;
    endproperty
    a_grant_gated: assert property (p_grant_gated) else $error("grant of gated source");
    property p_ack_clear;
        grant_ack_in && grant_out.valid |=> !grant_out.valid;
    endproperty
    a_ack_clear: assert property (p_ack_clear) else $error("grant held after ack");
    property p_status_sub;
        (status_out[5:0] & ~$past(src_req_in)) == 6'h00 && status_out[7:6] == 2'h0;
    endproperty
    a_status_sub: assert property (p_status_sub) else $error("status without request");
    c_grant_hi: cover property (grant_out.valid && grant_out.level == 2'h2);
    c_ack: cover property (grant_ack_in && grant_out.valid);
    c_done: cover property (service_done_in);
    c_level3: cover property (grant_out.valid && grant_out.level == 2'h3);
endmodule : iep_irq_asserts

bind iep_irq_ctrl iep_irq_asserts #(.NUM_SRC(NUM_SRC)) u_asserts (.clk_sys_in(clk_sys_in),
    .reset_in(reset_in), .bus_in(bus_in), .rdata_out(rdata_out), .src_req_in(src_req_in),
    .grant_ack_in(grant_ack_in), .service_done_in(service_done_in), .grant_out(grant_out),
    .status_out(status_out));

// file: tb/iep_core_model.sv
/* Core sequencer stand-in: acks grants, signals routine return.
   Assumes the bench steers it through ack_en_in and ret_in. */
`timescale 1ns/100ps
module iep_core_model (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic reset_in,
    // Steering from the bench
    input wire logic ack_en_in,
    input wire logic ret_in,
    // Block side
    input wire iep_pkg::iep_grant_t grant_in,
    output logic ack_out,
    output logic done_out
);
    // One-cycle ack; slow answers come from holding ack_en_in low
    always_ff @(posedge clk_sys_in) begin
        ack_out <= !reset_in && ack_en_in && grant_in.valid && !ack_out;
        done_out <= !reset_in && ret_in;
    end
endmodule : iep_core_model

// file: tb/tb_iep_irq_ctrl.sv
/* Self-checking bench for iep_irq_ctrl.
   Assumes iep_pkg, the core model and the checker are compiled first. */
`timescale 1ns/100ps
module tb_iep_irq_ctrl;
    logic clk_sys_in = 1'b0;
    logic reset_in = 1'b1;
    iep_pkg::iep_bus_req_t bus_in = '0;
    logic [5:0] src_req_in = 6'h00;
    logic ack_en = 1'b0;
    logic ret = 1'b0;
    logic grant_ack_in;
    logic service_done_in;
    logic [7:0] rdata_out;
    logic [7:0] status_out;
    logic [7:0] got;
    iep_pkg::iep_grant_t grant_out;
    int miscompares = 0;
    int total_checks = 0;
    int cycles = 0;
    // Rows of {enable write, request flags, expected status}
    logic [23:0] rows [8] = '{24'h3F3F00, 24'hBF2A2A, 24'h883F08, 24'h843F04, 24'h823F02,
        24'hA03F20, 24'h903F10, 24'h811501};
    always #20 clk_sys_in = ~clk_sys_in;
    iep_irq_ctrl iep_irq_ctrl_inst (.clk_sys_in(clk_sys_in), .reset_in(reset_in),
        .bus_in(bus_in), .rdata_out(rdata_out), .src_req_in(src_req_in),
        .grant_ack_in(grant_ack_in), .service_done_in(service_done_in),
        .grant_out(grant_out), .status_out(status_out));
    iep_core_model iep_core_model_inst (.clk_sys_in(clk_sys_in), .reset_in(reset_in),
        .ack_en_in(ack_en), .ret_in(ret), .grant_in(grant_out), .ack_out(grant_ack_in),
        .done_out(service_done_in));
    ////////////////////////////////////////////////////////////////
    task automatic chk8(input logic [7:0] g, input logic [7:0] e);
        total_checks++;
        if (g !== e) begin
            miscompares++;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk8
    task automatic bw(input logic [7:0] a, input logic [7:0] d, input logic bo = 1'b0,
        input logic [2:0] bs = 3'h0);
        @(posedge clk_sys_in);
        bus_in <= '{a, d, 1'b1, 1'b0, bo, bs};
        @(posedge clk_sys_in);
        bus_in <= '0;
    endtask : bw
    task automatic br(input logic [7:0] a);
        @(posedge clk_sys_in);
        bus_in <= '{a, 8'h00, 1'b0, 1'b1, 1'b0, 3'h0};
        @(posedge clk_sys_in);
        bus_in <= '0;
        #1 got = rdata_out;
    endtask : br
    task automatic wait_grant;
        for (int i = 0; i < 10; i++) begin
            @(posedge clk_sys_in);
            #1;
            if (grant_out.valid === 1'b1) break;
        end
    endtask : wait_grant
    // Ack the standing grant, then optionally return from the routine
    task automatic serve(input logic r);
        @(posedge clk_sys_in);
        ack_en <= 1'b1;
        repeat (3) @(posedge clk_sys_in);
        ack_en <= 1'b0;
        ret <= r;
        @(posedge clk_sys_in);
        ret <= 1'b0;
    endtask : serve
    task automatic end_sim;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : end_sim
    always @(posedge clk_sys_in) begin
        cycles++;
        if (cycles == 3000) begin
            miscompares++;
            end_sim();
        end
    end
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(posedge clk_sys_in);
        reset_in <= 1'b0;
        br(8'hA8); chk8(got, iep_pkg::IRQ_ENABLE_MASK_RST);
        br(8'hB7); chk8(got, iep_pkg::IRQ_PRIO_UPPER_RST);
        $display("test reset done");
        foreach (rows[i]) begin
            bw(8'hA8, rows[i][23:16]);
            @(posedge clk_sys_in);
            src_req_in <= rows[i][13:8];
            repeat (3) @(posedge clk_sys_in);
            #1 chk8(status_out, rows[i][7:0]);
        end
        $display("test table done");
        // Spare bits are never written one
        bw(8'hA8, 8'hBF); br(8'hA8); chk8(got, 8'hBF);
        bw(8'hB7, 8'h3F); br(8'hB7); chk8(got, 8'h3F);
        bw(8'hB7, 8'h00, 1'b1, 3'h5); br(8'hB7); chk8(got, 8'h3F);
        bw(8'hB8, 8'h3F); br(8'hB8); chk8(got, 8'h3F);
        bw(8'hB8, 8'h00, 1'b1, 3'h5); br(8'hB8); chk8(got, 8'h1F);
        bw(8'hA8, 8'h00, 1'b1, 3'h7); br(8'hA8); chk8(got, 8'h3F);
        bw(8'h00, 8'h5A); br(8'h00); chk8(got, 8'h00);
        br(8'hA8); chk8(got, 8'h3F);
        $display("test registers done");
        // Timer 2 at level 2, serial at level 3, ext0 at level 1
        bw(8'hA8, 8'h00); bw(8'hB7, 8'h30); bw(8'hB8, 8'h11);
        @(posedge clk_sys_in);
        src_req_in <= 6'h21;
        bw(8'hA8, 8'hB1); wait_grant;
        chk8({2'h0, grant_out}, 8'h36);
        serve(1'b0);
        repeat (4) @(posedge clk_sys_in);
        #1 chk8({7'h0, grant_out.valid}, 8'h00);
        br(8'hB9); chk8(got, 8'h75);
        @(posedge clk_sys_in);
        src_req_in <= 6'h31;
        wait_grant; chk8({2'h0, grant_out}, 8'h33);
        // Serial must drop before its return, or it nests again over timer 2
        serve(1'b1);
        src_req_in <= 6'h01;
        repeat (4) @(posedge clk_sys_in);
        #1 chk8({7'h0, grant_out.valid}, 8'h00);
        @(posedge clk_sys_in);
        ret <= 1'b1;
        @(posedge clk_sys_in);
        ret <= 1'b0;
        wait_grant; chk8({2'h0, grant_out}, 8'h21);
        serve(1'b1);
        src_req_in <= 6'h00;
        $display("test preempt done");
        bw(8'hA8, 8'h00); bw(8'hB7, 8'h00); bw(8'hB8, 8'h00);
        @(posedge clk_sys_in);
        src_req_in <= 6'h0A;
        bw(8'hA8, 8'h8A); wait_grant;
        chk8({2'h0, grant_out}, 8'h24);
        serve(1'b1);
        $display("test polling done");
        // Reset in mid-run, with requests standing
        reset_in <= 1'b1;
        repeat (2) @(posedge clk_sys_in);
        reset_in <= 1'b0;
        src_req_in <= 6'h00;
        br(8'hA8); chk8(got, iep_pkg::IRQ_ENABLE_MASK_RST);
        #1 chk8({7'h0, grant_out.valid}, 8'h00);
        $display("test reset again done");
        end_sim();
    end
endmodule : tb_iep_irq_ctrl
